//--- verification/tb_top.sv
// Self-checking bench for the indexed bit-set and fill-ones unit
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk_in, reset_in, instr_valid_in, extended_set_enable_in;
  logic [15:0] opcode_in;
  logic [11:0] frame_pointer_in, mem_addr_out;
  logic [7:0]  mem_rdata_in, mem_wdata_out;
  logic        mem_rd_out, mem_wr_out, busy_out, done_out, status_we_out;
  int          fails, num_checks;
  logic [19:0] wrq[$];
  logic [19:0] rdq[$];

  iof_exec #(.ADDR_W(12)) iof_exec_inst (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .instr_valid_in(instr_valid_in), .opcode_in(opcode_in),
    .extended_set_enable_in(extended_set_enable_in),
    .frame_pointer_in(frame_pointer_in), .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
    .busy_out(busy_out), .done_out(done_out),
    .status_we_out(status_we_out));

  task automatic check(input string name, input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Read data held for the whole instruction, so either sampling edge works
  task automatic run(input logic [15:0] op, input logic ext,
                     input logic [11:0] fp, input logic [7:0] rd,
                     input bit ok);
    int n;
    @(posedge sys_clk_in);
    instr_valid_in         <= 1'b1;
    opcode_in              <= op;
    extended_set_enable_in <= ext;
    frame_pointer_in       <= fp;
    mem_rdata_in           <= rd;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    n = 0;
    if (ok) begin
      do begin
        @(negedge sys_clk_in);
        n++;
        if (n > 10) begin
          fails++;
          end_sim();
        end
      end while (done_out !== 1'b1);
      check("done_latency", 20'(n), 20'h4);
    end else
      repeat (6) @(negedge sys_clk_in);
  endtask : run

  task automatic bset(input logic [2:0] b, input logic [7:0] k,
                      input logic [11:0] fp, input logic [7:0] d);
    logic [11:0] a;
    a = fp + {4'h0, k};
    rdq.push_back({8'h00, a});
    wrq.push_back({a, d | (8'h01 << b)});
    run({4'h8, b, 1'b0, k}, 1'b1, fp, d, 1'b1);
  endtask : bset

  task automatic fill(input logic [7:0] k, input logic [11:0] fp);
    wrq.push_back({fp + {4'h0, k}, 8'hff});
    run({8'h68, k}, 1'b1, fp, 8'h00, 1'b1);
  endtask : fill

  // Watcher: every read and write must match the oldest note
  always @(negedge sys_clk_in) if (reset_in === 1'b0) begin
    check("status_we", {19'h0, status_we_out}, 20'h0);
    if (mem_rd_out === 1'b1) begin
      if (rdq.size() == 0) check("stray_read", 20'h1, 20'h0);
      else check("rd_addr", {8'h00, mem_addr_out}, rdq.pop_front());
    end
    if (mem_wr_out === 1'b1) begin
      if (wrq.size() == 0) check("stray_write", 20'h1, 20'h0);
      else
        check("write", {mem_addr_out, mem_wdata_out},
              wrq.pop_front());
    end
  end

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    opcode_in = 16'h0000;
    extended_set_enable_in = 1'b0;
    frame_pointer_in = 12'h000;
    mem_rdata_in = 8'h00;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'hde39));
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    for (int b = 0; b < 8; b++)
      bset(b[2:0], 8'($urandom_range(95, 0)), 12'($urandom), 8'($urandom));
    bset(3'h7, 8'h5f, 12'hfff, 8'h55);
    $display("test bit_set finished");
    fill(8'h00, 12'($urandom));
    fill(8'h5f, 12'hfff);
    fill(8'($urandom_range(95, 0)), 12'($urandom));
    $display("test fill finished");
    // Refused forms: no read, no write, no done
    run(16'h6860, 1'b1, 12'h100, 8'h00, 1'b0);
    run(16'h8e60, 1'b1, 12'h100, 8'h00, 1'b0);
    run(16'h8e10, 1'b0, 12'h100, 8'h00, 1'b0);
    run(16'h8f10, 1'b1, 12'h100, 8'h00, 1'b0);
    run(16'h6910, 1'b1, 12'h100, 8'h00, 1'b0);
    $display("test refusals finished");
    check("queues_empty", 20'(wrq.size() + rdq.size()), 20'h0);
    end_sim();
  end
endmodule : tb_top

//--- verilog/iof_decode.sv
// Opcode decoder for indexed bit-set and fill-ones instructions
`timescale 1ns/1ps
`include "iof_map.svh"
module iof_decode (
  // Instruction
  input  wire logic [15:0]    opcode_in,
  input  wire logic           extended_set_enable_in,
  // Decode result
  output iof_pkg::iof_op_t    op_out,
  output logic      [2:0]     bit_sel_out,
  output logic      [7:0]     offset_out
);
  always_comb begin
    op_out      = iof_pkg::IOF_OP_NONE;
    bit_sel_out = opcode_in[`IOF_BITSET_SEL_POS +: 3];
    offset_out  = opcode_in[7:0];
    // Indexed form only with extension on and low offset
    if (extended_set_enable_in
        && opcode_in[7:0] <= `IOF_OFFSET_MAX) begin // RL8 RL6
      if (opcode_in[`IOF_BITSET_OP_POS +: 4] == `IOF_BITSET_OP_HI
          && !opcode_in[`IOF_ACCESS_POS]) begin // RL2
        op_out = iof_pkg::IOF_OP_BIT_SET;
      end else if (opcode_in[`IOF_FILL_OP_POS +: 8]
                   == `IOF_FILL_OP_HI) begin // RL5
        op_out = iof_pkg::IOF_OP_FILL;
      end
    end
  end
endmodule : iof_decode

//--- verilog/iof_exec.sv
// Four-phase execution unit for indexed bit-set and fill-ones
//
// Contract
// [RL1] Bit-set sets only the chosen bit 0..7 of the byte at pointer+offset.
// [RL2] Bit-set decodes as 1000, bit select, access bit zero, offset byte.
// [RL3] Bit-set runs decode, read, modify, write over the four phases.
// [RL4] Fill-ones writes ff to pointer+offset and touches no status flag.
// [RL5] Fill-ones decodes from upper byte 0110 1000 with offset low byte.
// [RL6] Fill-ones offsets above 95 are not taken in this mode.
// [RL7] Fill-ones completes in one cycle, processing Q3 and writing Q4.
// [RL8] With extension on and access zero, arguments up to 5f are offsets.
// [RL9] Address is the full frame pointer plus the zero-extended offset.
`timescale 1ns/1ps
`include "iof_map.svh"
module iof_exec #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // Instruction
  input  wire logic              instr_valid_in,
  input  wire logic [15:0]       opcode_in,
  input  wire logic              extended_set_enable_in,
  input  wire logic [ADDR_W-1:0] frame_pointer_in,
  // Data memory
  input  wire logic [7:0]        mem_rdata_in,
  output logic      [ADDR_W-1:0] mem_addr_out,
  output logic                   mem_rd_out,
  output logic                   mem_wr_out,
  output logic      [7:0]        mem_wdata_out,
  // Status
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   status_we_out
);
  // Pointer narrower than the offset byte cannot hold the sum
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_addr_w_check
    $error("iof_exec: ADDR_W must be 8..16");
  end

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} iof_phase_t;

  iof_pkg::iof_op_t  dec_op;
  logic [2:0]        dec_bit;
  logic [7:0]        dec_off;

  iof_decode u_decode (
    .opcode_in              (opcode_in),
    .extended_set_enable_in (extended_set_enable_in),
    .op_out                 (dec_op),
    .bit_sel_out            (dec_bit),
    .offset_out             (dec_off)
  );

  iof_phase_t        phase_q,  phase_d;
  iof_pkg::iof_op_t  op_q,     op_d;
  logic [2:0]        bit_q,    bit_d;
  logic [ADDR_W-1:0] addr_q,   addr_d;
  logic [7:0]        data_q,   data_d;
  logic              rd_q,     rd_d;
  logic              wr_q,     wr_d;
  logic              busy_q,   busy_d;
  logic              done_q,   done_d;
  logic              status_we_q, status_we_d;

  always_comb begin
    phase_d = phase_q;
    op_d    = op_q;
    bit_d   = bit_q;
    addr_d  = addr_q;
    data_d  = data_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    busy_d  = busy_q;
    done_d  = 1'b0;
    // Flags are never written by these two operations
    status_we_d = 1'b0; // RL4
    case (phase_q)
      Q1: begin
        // Decode; invalid words leave the unit idle
        if (instr_valid_in && dec_op != iof_pkg::IOF_OP_NONE) begin // RL3
          op_d    = dec_op;
          bit_d   = dec_bit;
          addr_d  = frame_pointer_in + ADDR_W'(dec_off); // RL9
          rd_d    = (dec_op == iof_pkg::IOF_OP_BIT_SET);
          busy_d  = 1'b1;
          phase_d = Q2;
        end
      end
      Q2: begin
        // Read phase: memory answers the read strobe here
        if (op_q == iof_pkg::IOF_OP_BIT_SET) begin
          data_d = mem_rdata_in; // RL3
        end
        phase_d = Q3;
      end
      Q3: begin
        if (op_q == iof_pkg::IOF_OP_BIT_SET) begin
          data_d = data_q | (8'h01 << bit_q); // RL1
        end else begin
          data_d = `IOF_FILL_VALUE; // RL4 RL7
        end
        wr_d    = 1'b1;
        phase_d = Q4;
      end
      Q4: begin
        // Write strobe is high during this phase
        busy_d  = 1'b0;
        done_d  = 1'b1; // RL7
        phase_d = Q1;
      end
      default: phase_d = Q1;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q <= Q1;
      op_q    <= iof_pkg::IOF_OP_NONE;
      bit_q   <= 3'h0;
      addr_q  <= ADDR_W'(`IOF_ADDR_RESET);
      data_q  <= `IOF_DATA_RESET;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      status_we_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      op_q    <= op_d;
      bit_q   <= bit_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      status_we_q <= status_we_d;
    end
  end

  assign mem_addr_out  = addr_q;
  assign mem_rd_out    = rd_q;
  assign mem_wr_out    = wr_q;
  assign mem_wdata_out = data_q;
  assign busy_out      = busy_q;
  assign done_out      = done_q;
  // Kept in a flop so every output leaves a register
  assign status_we_out = status_we_q; // RL4

  // One clock domain: shared clocking and reset for every check
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  a_bitset_onebit: assert property ( // RL1
    wr_q && op_q == iof_pkg::IOF_OP_BIT_SET |->
      data_q == ($past(mem_rdata_in, 2) | (8'h01 << bit_q)))
    else $error("bit-set result wrong");

  a_bitset_setbit: assert property ( // RL1
    wr_q && op_q == iof_pkg::IOF_OP_BIT_SET |-> data_q[bit_q])
    else $error("selected bit not set");

  a_bitset_decode: assert property ( // RL2
    phase_q == Q1 && instr_valid_in && extended_set_enable_in
    && opcode_in[15:12] == 4'h8 && !opcode_in[8] && opcode_in[7:0] <= 8'h5f
    |=> rd_q && op_q == iof_pkg::IOF_OP_BIT_SET)
    else $error("bit-set not decoded");

  a_bitset_phases: assert property ( // RL3
    rd_q |=> !wr_q ##1 wr_q ##1 done_q)
    else $error("bit-set phase order wrong");

  a_read_bitset: assert property ( // RL3
    rd_q |-> op_q == iof_pkg::IOF_OP_BIT_SET)
    else $error("read strobe outside bit-set");

  a_idle_quiet: assert property ( // RL3
    !busy_q |-> !rd_q && !wr_q)
    else $error("memory strobe while idle");

  a_fill_value: assert property ( // RL4
    wr_q && op_q == iof_pkg::IOF_OP_FILL |-> data_q == 8'hff && !status_we_out)
    else $error("fill value wrong");

  a_fill_decode: assert property ( // RL5
    phase_q == Q1 && instr_valid_in && extended_set_enable_in
    && opcode_in[15:8] == 8'h68 && opcode_in[7:0] <= 8'h5f
    |=> op_q == iof_pkg::IOF_OP_FILL && !rd_q ##2 wr_q)
    else $error("fill not decoded");

  a_fill_range: assert property ( // RL6
    phase_q == Q1 && instr_valid_in && opcode_in[7:0] > 8'h5f |=> !busy_q)
    else $error("offset above 95 accepted");

  a_fill_onecycle: assert property ( // RL7
    $rose(busy_q) |-> busy_q [*3] ##1 !busy_q && done_q)
    else $error("instruction not four phases");

  a_write_pulse: assert property ( // RL7
    wr_q |=> !wr_q && done_q)
    else $error("write strobe not one phase");

  a_ext_disable: assert property ( // RL8
    phase_q == Q1 && !extended_set_enable_in |=> !busy_q)
    else $error("executed with extension off");

  a_addr_sum: assert property ( // RL9
    $rose(busy_q) |->
      addr_q == $past(frame_pointer_in) + ADDR_W'($past(opcode_in[7:0])))
    else $error("address sum wrong");

  a_addr_held: assert property ( // RL9
    busy_q && $past(busy_q) |-> $stable(addr_q))
    else $error("address moved mid-instruction");
endmodule : iof_exec

//--- verilog/iof_map.svh
// Constants for the indexed offset bit-set and fill-ones execution unit
`ifndef IOF_MAP_SVH
`define IOF_MAP_SVH
`define IOF_BITSET_OP_HI  4'h8
`define IOF_BITSET_OP_POS 12
`define IOF_BITSET_SEL_POS 9
`define IOF_ACCESS_POS    8
`define IOF_FILL_OP_HI    8'h68
`define IOF_FILL_OP_POS   8
`define IOF_OFFSET_MAX    8'h5f
`define IOF_FILL_VALUE    8'hff
`define IOF_ADDR_RESET    12'h000
`define IOF_DATA_RESET    8'h00
`define IOF_PHASE_RESET   2'h0
`endif

//--- verilog/iof_pkg.sv
// Types shared by the indexed offset execution unit
package iof_pkg;
  typedef enum logic [1:0] {
    IOF_OP_NONE,
    IOF_OP_BIT_SET,
    IOF_OP_FILL
  } iof_op_t;
endpackage : iof_pkg
